/* File: logic/rss_cfg.svh */
// constants of the rotate/set/sleep execute block
// assumes a 100 MHz mclk and APB byte addresses on a 32-bit bus
// Function
// - rotate-right opcode is 0100 00, then d, a and 8-bit address
// - rotate moves bit n to n-1, bit 0 to bit 7, carry untouched
// - d=0 puts rotated value in W, file register unchanged
// - d=1 writes rotated value back to file register
// - a=0 addresses the access bank, bank register ignored
// - a=1 forms address from bank register
// - extended set with a=0 and f<=5Fh uses indexed literal offset
// - rotate updates only N and Z; C, DC, OV kept
// - fill opcode 0110 100a writes FFh, changes no flags
// - fill with a=0 uses access bank, a=1 uses bank register
// - fixed word 0003h is the sleep instruction, no operands
// - sleep clears the power-down flag
// - sleep sets the time-out flag
// - sleep clears watchdog counter and its postscaler
// - sleep entered in final phase, oscillator halted
// - watchdog wake from sleep clears the time-out flag
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

`define RSS_ROTR_OPC      6'h10
`define RSS_FILL_OPC      7'h34
`define RSS_SLEEP_WORD    16'h0003
`define RSS_FILL_VALUE    8'hff
`define RSS_LIT_OFS_MAX   8'h5f
`define RSS_ACC_SPLIT     8'h80
`define RSS_ACC_HI_BANK   4'hf
`define RSS_ACC_LO_BANK   4'h0
`define RSS_WDT_CLR_VALUE 8'h00

`define RSS_OFS_CTRL      8'h00
`define RSS_OFS_FLAGS     8'h04
`define RSS_OFS_POWER     8'h08
`define RSS_OFS_WREG      8'h0c
`define RSS_OFS_BANK      8'h10
`define RSS_OFS_FADDR     8'h14
`define RSS_OFS_FDATA     8'h18
`define RSS_OFS_FSR2      8'h1c

`define RSS_FLAG_C        0
`define RSS_FLAG_DC       1
`define RSS_FLAG_Z        2
`define RSS_FLAG_OV       3
`define RSS_FLAG_N        4
`define RSS_PWR_TO        0
`define RSS_PWR_PD        1
`define RSS_PWR_SLEEP     2

`define RSS_RST_FLAGS     5'h00
`define RSS_RST_TO        1'b1
`define RSS_RST_PD        1'b1
`define RSS_RST_WREG      8'h00
`define RSS_RST_BANK      4'h0
`define RSS_RST_FADDR     12'h000
`define RSS_RST_FSR2      12'h000
`define RSS_RST_EXT       1'b0

`endif

/* File: logic/rss_pkg.sv */
// types shared by the execute block and its decoder
// assumes nothing of its surroundings
package rss_pkg;

    typedef enum logic [1:0] {
        RSS_OP_NONE  = 2'b00,
        RSS_OP_ROTR  = 2'b01,
        RSS_OP_FILL  = 2'b10,
        RSS_OP_SLEEP = 2'b11
    } rss_op_e;

    typedef enum logic [2:0] {
        RSS_PH_IDLE = 3'b000,
        RSS_PH_Q1   = 3'b001,
        RSS_PH_Q2   = 3'b010,
        RSS_PH_Q3   = 3'b011,
        RSS_PH_Q4   = 3'b100
    } rss_phase_e;

    typedef struct packed {
        rss_op_e     op;
        logic        toW;
        logic [11:0] addr;
    } rss_decoded_s;

endpackage : rss_pkg

/* File: logic/rss_decode.sv */
// instruction decoder and file address former
// assumes instruction and bank values are stable on mclk
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_decode
    import rss_pkg::*;
(
    input  wire logic [15:0] instr,
    input  wire logic        extEnable,
    input  wire logic [3:0]  bank,
    input  wire logic [11:0] fsr2,
    output rss_decoded_s     dec
);

    wire [7:0]  fileOfs   = instr[7:0];
    wire        bankBit   = instr[8];
    wire        destBit   = instr[9];
    wire        isRotr    = instr[15:10] == `RSS_ROTR_OPC;
    wire        isFill    = instr[15:9] == `RSS_FILL_OPC;
    wire        isSleep   = instr == `RSS_SLEEP_WORD;
    wire        indexed   = extEnable && !bankBit &&
                            (fileOfs <= `RSS_LIT_OFS_MAX);
    wire [11:0] idxAddr   = fsr2 + {4'h0, fileOfs};
    wire [11:0] accAddr   = (fileOfs < `RSS_ACC_SPLIT) ?
                            {`RSS_ACC_LO_BANK, fileOfs} :
                            {`RSS_ACC_HI_BANK, fileOfs};
    wire [11:0] bankAddr  = {bank, fileOfs};

    assign dec.op   = isSleep ? RSS_OP_SLEEP :
                      isRotr  ? RSS_OP_ROTR  :
                      isFill  ? RSS_OP_FILL  : RSS_OP_NONE;
    assign dec.toW  = isRotr && !destBit;
    assign dec.addr = indexed ? idxAddr :
                      bankBit ? bankAddr : accAddr;

endmodule : rss_decode

/* File: logic/rss_exec.sv */
// rotate-right, fill-ones and sleep execute core with APB registers
// assumes instr comes from fetch logic on mclk; wake inputs are async
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_exec
    import rss_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [15:0] instr,
    input  wire logic        instrValid,
    output logic             instrReady,
    input  wire logic        wakeReq,
    input  wire logic        wdtTimeout,
    output logic             sleeping,
    output logic             oscEnable,
    output logic             wdtClear
);

    rss_phase_e   phase;
    rss_phase_e   next_phase;
    rss_decoded_s decNow;
    rss_decoded_s dec;
    logic [15:0]  instrReg;
    logic [7:0]   operand;
    logic [7:0]   result;
    logic [7:0]   fileMem [0:4095];
    logic [1:0]   wakeMeta;
    logic [1:0]   wakeSync;
    logic         extEnable;
    logic [4:0]   flags;
    logic         toFlag;
    logic         pdFlag;
    logic [7:0]   wReg;
    logic [3:0]   bank;
    logic [11:0]  faddr;
    logic [11:0]  fsr2;

    // decode sees the latched word, not the live fetch bus
    rss_decode u_decode (
        .instr     (instrReg),
        .extEnable (extEnable),
        .bank      (bank),
        .fsr2      (fsr2),
        .dec       (decNow)
    );

    // apb decode; pready registered from setup, so every access completes with no wait state
    wire        apbSetup  = psel && !penable;
    wire        apbWr     = psel && penable && pwrite && pready;
    wire [7:0]  regOfs    = paddr[7:0];
    wire        upperZero = paddr[31:8] == 24'h000000;
    wire        selCtrl   = upperZero && (regOfs == `RSS_OFS_CTRL);
    wire        selFlags  = upperZero && (regOfs == `RSS_OFS_FLAGS);
    wire        selPower  = upperZero && (regOfs == `RSS_OFS_POWER);
    wire        selWreg   = upperZero && (regOfs == `RSS_OFS_WREG);
    wire        selBank   = upperZero && (regOfs == `RSS_OFS_BANK);
    wire        selFaddr  = upperZero && (regOfs == `RSS_OFS_FADDR);
    wire        selFdata  = upperZero && (regOfs == `RSS_OFS_FDATA);
    wire        selFsr2   = upperZero && (regOfs == `RSS_OFS_FSR2);
    wire        mapped    = selCtrl || selFlags || selPower || selWreg ||
                            selBank || selFaddr || selFdata || selFsr2;
    wire [2:0]  powerBits = {sleeping, pdFlag, toFlag};
    wire [31:0] readMux   =
        selCtrl  ? {31'h00000000, extEnable} :
        selFlags ? {27'h0000000, flags} :
        selPower ? {29'h00000000, powerBits} :
        selWreg  ? {24'h000000, wReg} :
        selBank  ? {28'h0000000, bank} :
        selFaddr ? {20'h00000, faddr} :
        selFdata ? {24'h000000, fileMem[faddr]} :
        selFsr2  ? {20'h00000, fsr2} : 32'h00000000;

    // core control
    wire inQ4       = phase == RSS_PH_Q4;
    wire takeInstr  = (phase == RSS_PH_IDLE) && instrValid && instrReady;
    wire enterSleep = inQ4 && (dec.op == RSS_OP_SLEEP);
    wire wakeAny    = sleeping && (wakeSync[0] || wakeSync[1]);
    wire wdtWake    = sleeping && wakeSync[1];
    wire coreWWr    = inQ4 && (dec.op == RSS_OP_ROTR) && dec.toW;
    wire coreFileWr = inQ4 && ((dec.op == RSS_OP_FILL) ||
                      ((dec.op == RSS_OP_ROTR) && !dec.toW));
    // rotate touches N and Z only
    wire flagUpd    = inQ4 && (dec.op == RSS_OP_ROTR);
    wire next_sleep = sleeping ? !wakeAny : enterSleep;
    wire next_ready = (next_phase == RSS_PH_IDLE) && !next_sleep;

    always_comb
    begin
        next_phase = phase;
        case (phase)
            RSS_PH_IDLE: next_phase = takeInstr ? RSS_PH_Q1 : RSS_PH_IDLE;
            RSS_PH_Q1:   next_phase = RSS_PH_Q2;
            RSS_PH_Q2:   next_phase = RSS_PH_Q3;
            RSS_PH_Q3:   next_phase = RSS_PH_Q4;
            RSS_PH_Q4:   next_phase = RSS_PH_IDLE;
            default:     next_phase = RSS_PH_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            phase      <= RSS_PH_IDLE;
            instrReady <= 1'b0;
        end
        else
        begin
            phase      <= next_phase;
            instrReady <= next_ready;
        end
    end

    // two flops per wake pin; only the second stage is read by logic
    // bit 0 is the wake pin, bit 1 the watchdog time-out
    wire [1:0]  wakeRaw   = {wdtTimeout, wakeReq};
    genvar      gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_wake_sync
            always_ff @(posedge mclk)
            begin
                if (reset)
                begin
                    wakeMeta[gi] <= 1'b0;
                    wakeSync[gi] <= 1'b0;
                end
                else
                begin
                    wakeMeta[gi] <= wakeRaw[gi];
                    wakeSync[gi] <= wakeMeta[gi];
                end
            end
        end
    endgenerate

    // q1 latches the decode, q2 reads the operand
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            instrReg <= 16'h0000;
            dec      <= '0;
            operand  <= 8'h00;
        end
        else
        begin
            if (takeInstr)
                instrReg <= instr;
            if (phase == RSS_PH_Q1)
                dec <= decNow;
            if (phase == RSS_PH_Q2)
                operand <= fileMem[dec.addr];
        end
    end

    // q3 process data
    always_ff @(posedge mclk)
    begin
        if (reset)
            result <= 8'h00;
        else if (phase == RSS_PH_Q3)
        begin
            if (dec.op == RSS_OP_ROTR)
                result <= {operand[0], operand[7:1]};
            else
                result <= `RSS_FILL_VALUE;
        end
    end

    // no reset: data memory content is undefined at power-up
    always_ff @(posedge mclk)
    begin
        if (apbWr && selFdata)
            fileMem[faddr] <= pwdata[7:0];
        // core write lands last, so it wins an address clash
        if (coreFileWr)
            fileMem[dec.addr] <= result;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            wReg  <= `RSS_RST_WREG;
            flags <= `RSS_RST_FLAGS;
        end
        else
        begin
            if (apbWr && selWreg)
                wReg <= pwdata[7:0];
            if (coreWWr)
                wReg <= result;
            if (apbWr && selFlags)
                flags <= pwdata[4:0];
            if (flagUpd)
            begin
                flags[`RSS_FLAG_N] <= result[7];
                flags[`RSS_FLAG_Z] <= result == 8'h00;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            extEnable <= `RSS_RST_EXT;
            bank      <= `RSS_RST_BANK;
            faddr     <= `RSS_RST_FADDR;
            fsr2      <= `RSS_RST_FSR2;
        end
        else if (apbWr)
        begin
            if (selCtrl)
                extEnable <= pwdata[0];
            if (selBank)
                bank <= pwdata[3:0];
            if (selFaddr)
                faddr <= pwdata[11:0];
            if (selFsr2)
                fsr2 <= pwdata[11:0];
        end
    end

    // status bits; set and cleared by hardware only
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            toFlag <= `RSS_RST_TO;
            pdFlag <= `RSS_RST_PD;
        end
        else
        begin
            if (enterSleep)
                toFlag <= 1'b1;
            else if (wdtWake)
                toFlag <= 1'b0;
            if (enterSleep)
                pdFlag <= 1'b0;
        end
    end

    // power state; oscillator stays halted until a synced wake
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sleeping  <= 1'b0;
            oscEnable <= 1'b1;
            wdtClear  <= 1'b0;
        end
        else
        begin
            sleeping  <= next_sleep;
            oscEnable <= !next_sleep;
            wdtClear  <= enterSleep;
        end
    end

    // read data caught at setup, so it stands through the access cycle
    wire        apbRead   = apbSetup && !pwrite;
    wire        next_err  = apbSetup && !mapped;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= apbSetup;
            pslverr <= next_err;
            if (apbRead)
                prdata <= readMux;
        end
    end

endmodule : rss_exec

/* File: dv/rss_exec_assertions.sv */
// port timing checks of the execute block
// assumes a bind onto rss_exec, one clock domain
`timescale 1ns/1ps
`include "rss_cfg.svh"
module rss_exec_chk
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [15:0] instr,
    input wire logic        instrValid,
    input wire logic        instrReady,
    input wire logic        wakeReq,
    input wire logic        wdtTimeout,
    input wire logic        sleeping,
    input wire logic        oscEnable,
    input wire logic        wdtClear
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic take = instrValid && instrReady;
    wire logic isSleep = instr == `RSS_SLEEP_WORD;
    sequence busy_four;
        (!instrReady && !sleeping) [*4];
    endsequence
    sequence gone_asleep;
        sleeping && !oscEnable && wdtClear ##1 !wdtClear;
    endsequence
    apb_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    apb_single_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    apb_err_a: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside access");
    instr_busy_a: assert property (
        take && !isSleep |-> ##1 busy_four ##1 instrReady)
        else $error("instruction cycle length wrong");
    sleep_entry_a: assert property (
        take && isSleep |-> ##1 busy_four ##1 gone_asleep)
        else $error("sleep entry wrong");
    sleep_hold_a: assert property (
        sleeping |-> !oscEnable && !instrReady)
        else $error("core active while asleep");
    wake_bound_a: assert property (
        sleeping && (wakeReq || wdtTimeout) |-> ##[1:4] !sleeping)
        else $error("no wake");
    wake_resume_a: assert property (
        $fell(sleeping) |-> oscEnable && instrReady)
        else $error("wake left core halted");
    clear_asleep_a: assert property (
        wdtClear |-> sleeping && !oscEnable)
        else $error("watchdog clear outside sleep");
endmodule : rss_exec_chk

bind rss_exec rss_exec_chk i_chk (.mclk, .reset, .psel, .penable,
    .pready, .pslverr, .instr, .instrValid, .instrReady, .wakeReq,
    .wdtTimeout, .sleeping, .oscEnable, .wdtClear);

/* File: dv/rss_exec_bench.sv */
// self-checking bench of the execute block
// assumes rss_exec with APB registers and the bound checker
`timescale 1ns/1ps
`include "rss_cfg.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module rss_exec_bench;
    logic        mclk, reset, psel, penable, pwrite;
    logic [31:0] paddr, pwdata, prdata, r;
    logic        pready, pslverr, e, instrValid, instrReady;
    logic [15:0] instr;
    logic        wakeReq, wdtTimeout, sleeping, oscEnable, wdtClear;
    int          err_total, check_count;
    int          clrs = 0;
    logic [15:0] fw [4] = '{16'h6810, 16'h6860, 16'h6944, 16'h6890};
    logic [11:0] fa [4] = '{12'h310, 12'h060, 12'h244, 12'hf90};

    rss_exec i_dut (.mclk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .instr, .instrValid,
        .instrReady, .wakeReq, .wdtTimeout, .sleeping, .oscEnable,
        .wdtClear);

    initial
    begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) if (wdtClear === 1'b1) clrs <= clrs + 1;

    task print_verdict;
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task apb(input logic w, input logic [31:0] a, d);
        int n;
        begin
            n = 0;
            @(posedge mclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge mclk);
            penable <= 1'b1;
            // pready is taken at the same edge that commits the access
            @(posedge mclk);
            while (pready !== 1'b1 && n < 20)
            begin
                n++;
                @(posedge mclk);
            end
            if (pready !== 1'b1)
                err_total++;
            r = prdata;
            e = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task rd(input logic [31:0] a, input logic [31:0] x, input string nm);
        apb(0, a, 0);
        `CHK(nm, x, r)
    endtask : rd

    task exec(input logic [15:0] w);
        while (instrReady !== 1'b1)
            @(posedge mclk);
        @(posedge mclk);
        instr      <= w;
        instrValid <= 1'b1;
        @(posedge mclk);
        instrValid <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask : exec

    initial
    begin
        repeat (4000) @(posedge mclk);
        err_total++;
        print_verdict();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, instr, instrValid} = '0;
        {wakeReq, wdtTimeout, err_total, check_count} = '0;
        reset = 1;
        repeat (20) @(posedge mclk);
        reset <= 0;
        rd(`RSS_OFS_POWER, 32'h3, "power");
        rd(`RSS_OFS_FLAGS, 32'h0, "flags");
        apb(0, 32'h20, 0);
        `CHK("unmapped", 1'b1, e)
        `CHK("unmapped rd", 32'h0, r)
        apb(1, `RSS_OFS_POWER, 0);
        rd(`RSS_OFS_POWER, 32'h3, "power ro");
        apb(1, `RSS_OFS_BANK, 2);
        apb(1, `RSS_OFS_FADDR, 32'h235);
        apb(1, `RSS_OFS_FDATA, 32'hd7);
        apb(1, `RSS_OFS_FLAGS, 32'h0b);
        exec(16'h4335);
        rd(`RSS_OFS_FDATA, 32'heb, "rot file");
        rd(`RSS_OFS_FLAGS, 32'h1b, "rot flags");
        rd(`RSS_OFS_WREG, 32'h0, "rot w");
        apb(1, `RSS_OFS_FADDR, 32'h020);
        apb(1, `RSS_OFS_FDATA, 32'h01);
        apb(1, `RSS_OFS_FLAGS, 32'h04);
        exec(16'h4020);
        rd(`RSS_OFS_WREG, 32'h80, "rot to w");
        rd(`RSS_OFS_FDATA, 32'h01, "rot src");
        rd(`RSS_OFS_FLAGS, 32'h10, "rot nz");
        exec(16'h0002);
        rd(`RSS_OFS_POWER, 32'h3, "near sleep");
        rd(`RSS_OFS_WREG, 32'h80, "no-op w");
        rd(`RSS_OFS_FDATA, 32'h01, "no-op file");
        apb(1, `RSS_OFS_CTRL, 1);
        apb(1, `RSS_OFS_FSR2, 32'h300);
        for (int i = 0; i < 4; i++)
        begin
            apb(1, `RSS_OFS_FADDR, {20'h0, fa[i]});
            apb(1, `RSS_OFS_FDATA, 32'h5a);
            exec(fw[i]);
            rd(`RSS_OFS_FDATA, 32'hff, "fill");
        end
        rd(`RSS_OFS_FLAGS, 32'h10, "fill flags");
        exec(`RSS_SLEEP_WORD);
        rd(`RSS_OFS_POWER, 32'h5, "sleep");
        wdtTimeout <= 1;
        repeat (8) @(posedge mclk);
        wdtTimeout <= 0;
        rd(`RSS_OFS_POWER, 32'h0, "wdt wake");
        exec(`RSS_SLEEP_WORD);
        wakeReq <= 1;
        repeat (8) @(posedge mclk);
        wakeReq <= 0;
        rd(`RSS_OFS_POWER, 32'h1, "pin wake");
        `CHK("clears", 2, clrs)
        print_verdict();
    end
endmodule : rss_exec_bench
